// ### include/vreg_cmd_pkg.sv
// Constants and types shared by the virtual register command decoder.
package vreg_cmd_pkg;

  // Command address width and the virtual command addresses.
  localparam int          ADDR_W             = 12;
  localparam logic [11:0] ADDR_APPLY_SHADOW  = 12'h900;
  localparam logic [11:0] ADDR_CAPTURE_SHADOW = 12'ha00;
  localparam logic [11:0] ADDR_FW_VERSION    = 12'hc00;
  localparam logic [11:0] ADDR_RAW_TEMP      = 12'hc01;
  localparam logic [11:0] ADDR_HALT_ENTRY    = 12'hc02;
  localparam logic [11:0] ADDR_LP_ENTRY      = 12'hc03;
  localparam logic [11:0] ADDR_LP_EXIT       = 12'hc04;

  // Read data is one 16-bit word; one-byte answers sit in the low byte.
  localparam int          DATA_W             = 16;
  localparam logic [7:0]  FILLER_BYTE        = 8'h00;
  localparam logic [7:0]  ZERO_BYTE          = 8'h00;
  localparam logic [15:0] ZERO_WORD          = 16'h0000;

  // Two temperature samples are averaged: shift by one.
  localparam int          AVG_SHIFT          = 1;

  // Decoder sequencing states.
  typedef enum logic [2:0] {
    CMD_IDLE    = 3'b001,
    CMD_MEASURE = 3'b010,
    CMD_READY   = 3'b100
  } cmd_state_e;

  // Averager sequencing states.
  typedef enum logic [1:0] {
    AVG_IDLE   = 2'b01,
    AVG_SAMPLE = 2'b10
  } avg_state_e;

endpackage

// ### core/temp_pair_averager.sv
// Requests die temperature samples and returns their average.
`timescale 1ns/1ps
`default_nettype none

module temp_pair_averager
  import vreg_cmd_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // Control.
  input  wire logic         start_i,
  output logic              done_o,
  output logic [W-1:0]      result_o,
  // Sampler handshake.
  output logic              sample_req_o,
  input  wire logic         sample_ack_i,
  input  wire logic [W-1:0] sample_i
);

  localparam int          SAMPLES = 1 << AVG_SHIFT;
  localparam int          CNT_W   = AVG_SHIFT + 1;
  localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(SAMPLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  avg_state_e           state,  next_state;
  logic [CNT_W-1:0]     cnt,    next_cnt;
  logic [W+AVG_SHIFT-1:0] sum,  next_sum;
  logic [W-1:0]         next_result;
  logic                 next_done;
  logic                 next_req;
  logic [W+AVG_SHIFT-1:0] acc;

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_sum    = sum;
    next_result = result_o;
    next_done   = 1'b0;
    next_req    = sample_req_o;
    acc         = sum + (W+AVG_SHIFT)'(sample_i);
    case (state)
      AVG_IDLE: begin
        if (start_i) begin
          next_state = AVG_SAMPLE;
          next_cnt   = '0;
          next_sum   = '0;
          next_req   = 1'b1;
        end
      end
      AVG_SAMPLE: begin
        if (sample_ack_i) begin
          next_sum = acc;
          if (cnt == LAST_CNT) begin
            // Sum is wide enough that the average cannot overflow.
            next_result = W'(acc >> AVG_SHIFT);
            next_done   = 1'b1;
            next_req    = 1'b0;
            next_state  = AVG_IDLE;
          end else begin
            next_cnt = cnt + CNT_ONE;
          end
        end
      end
      default: begin
        next_state = AVG_IDLE;
        next_req   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state        <= AVG_IDLE;
      cnt          <= '0;
      sum          <= '0;
      result_o     <= '0;
      done_o       <= 1'b0;
      sample_req_o <= 1'b0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      sum          <= next_sum;
      result_o     <= next_result;
      done_o       <= next_done;
      sample_req_o <= next_req;
    end
  end

endmodule // temp_pair_averager

`default_nettype wire

// ### core/virtual_register_command_decoder.sv
// Decoder for read-triggered virtual command registers.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Command addresses are read-only virtual locations acted on by reads.
// - A read at the apply address copies the four shadows into live regs.
// - A read at the capture address copies the live regs into the shadows.
// - A read at the version address returns the two-byte firmware version.
// - A read at the raw temperature address averages two die samples.
// - The average is returned as two bytes, low byte sent first.
// - A read at the halt address puts the device in its stop state.
// - A read at the reduced-power entry address enters low-power state.
// - A read at the reduced-power exit address returns to normal operation.
module virtual_register_command_decoder
  import vreg_cmd_pkg::*;
#(
  parameter int          CFG_W          = 16,
  parameter logic [15:0] FW_VERSION     = 16'h0100, // Arbitrary value.
  parameter logic [15:0] CONV_CFG_RST   = 16'h0000,
  parameter logic [15:0] CONV_RATE_RST  = 16'h0000,
  parameter logic [15:0] CONV_ACQ_RST   = 16'h0000,
  parameter logic [15:0] SPI_CFG_RST    = 16'h0000
) (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // Read requests from the serial slave framer.
  input  wire logic              cmd_start_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic              cmd_done_i,
  output logic [DATA_W-1:0]      rd_data_o,
  output logic                   rd_ready_o,
  output logic                   cmd_valid_o,
  // Shadow configuration copies.
  input  wire logic [CFG_W-1:0]  converter_config_shadow_i,
  input  wire logic [CFG_W-1:0]  converter_rate_shadow_i,
  input  wire logic [CFG_W-1:0]  converter_acquisition_shadow_i,
  input  wire logic [CFG_W-1:0]  serial_port_config_shadow_i,
  output logic                   capture_shadow_o,
  // Live hardware registers.
  output logic [CFG_W-1:0]       live_converter_config_o,
  output logic [CFG_W-1:0]       live_converter_rate_o,
  output logic [CFG_W-1:0]       live_converter_acquisition_o,
  output logic [CFG_W-1:0]       live_serial_port_config_o,
  // Power states.
  input  wire logic              wake_i,
  output logic                   halt_o,
  output logic                   reduced_power_state_o,
  // Temperature sampler.
  output logic                   temp_sample_req_o,
  input  wire logic              temp_sample_ack_i,
  input  wire logic [DATA_W-1:0] temp_sample_i
);

  cmd_state_e        state,      next_state;
  logic [ADDR_W-1:0] addr,       next_addr;
  logic [DATA_W-1:0] next_rd_data;
  logic              next_rd_ready;
  logic              next_cmd_valid;
  logic              next_capture;
  logic [CFG_W-1:0]  next_cfg, next_rate, next_acq, next_spi;
  logic              next_halt;
  logic              next_low_power;
  logic              avg_start;
  logic              avg_done;
  logic [DATA_W-1:0] avg_result;
  logic              fire;
  logic              wake_meta;
  logic              wake_sync;

  temp_pair_averager #(
    .W (DATA_W)
  ) u_avg (
    .clk_i        (clk_i),
    .rstn_i       (rstn_i),
    .start_i      (avg_start),
    .done_o       (avg_done),
    .result_o     (avg_result),
    .sample_req_o (temp_sample_req_o),
    .sample_ack_i (temp_sample_ack_i),
    .sample_i     (temp_sample_i)
  );

  // The wake pin is asynchronous to the system clock.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      wake_meta <= wake_i;
      wake_sync <= wake_meta;
    end
  end

  assign fire = (state == CMD_READY) && cmd_done_i;

  always_comb begin
    next_state     = state;
    next_addr      = addr;
    next_rd_data   = rd_data_o;
    next_rd_ready  = rd_ready_o;
    next_cmd_valid = cmd_valid_o;
    next_capture   = 1'b0;
    next_cfg       = live_converter_config_o;
    next_rate      = live_converter_rate_o;
    next_acq       = live_converter_acquisition_o;
    next_spi       = live_serial_port_config_o;
    next_halt      = halt_o;
    next_low_power = reduced_power_state_o;
    avg_start      = 1'b0;
    // Wake only ends the stop state; a halt read in the same cycle wins.
    if (wake_sync) begin
      next_halt = 1'b0;
    end
    if (fire) begin
      next_state    = CMD_IDLE;
      next_rd_ready = 1'b0;
      case (addr)
        ADDR_APPLY_SHADOW: begin
          next_cfg  = converter_config_shadow_i;
          next_rate = converter_rate_shadow_i;
          next_acq  = converter_acquisition_shadow_i;
          next_spi  = serial_port_config_shadow_i;
        end
        ADDR_CAPTURE_SHADOW: next_capture = 1'b1;
        ADDR_HALT_ENTRY: next_halt = 1'b1;
        ADDR_LP_ENTRY: next_low_power = 1'b1;
        ADDR_LP_EXIT: next_low_power = 1'b0;
        default: next_low_power = reduced_power_state_o;
      endcase
    end
    if (state == CMD_MEASURE) begin
      if (avg_done) begin
        next_rd_data  = avg_result;
        next_rd_ready = 1'b1;
        next_state    = CMD_READY;
      end
    end else if (cmd_start_i) begin
      // A new read abandons an unfinished one without acting on it.
      next_addr      = cmd_addr_i;
      next_cmd_valid = 1'b1;
      next_rd_ready  = 1'b1;
      next_state     = CMD_READY;
      case (cmd_addr_i)
        ADDR_FW_VERSION: next_rd_data = FW_VERSION;
        ADDR_RAW_TEMP: begin
          avg_start     = 1'b1;
          next_rd_ready = 1'b0;
          next_rd_data  = ZERO_WORD;
          next_state    = CMD_MEASURE;
        end
        ADDR_APPLY_SHADOW, ADDR_CAPTURE_SHADOW, ADDR_HALT_ENTRY,
        ADDR_LP_ENTRY, ADDR_LP_EXIT: next_rd_data = {ZERO_BYTE, FILLER_BYTE};
        default: begin
          next_rd_data   = ZERO_WORD;
          next_cmd_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state                        <= CMD_IDLE;
      addr                         <= '0;
      rd_data_o                    <= ZERO_WORD;
      rd_ready_o                   <= 1'b0;
      cmd_valid_o                  <= 1'b0;
      capture_shadow_o             <= 1'b0;
      live_converter_config_o      <= CFG_W'(CONV_CFG_RST);
      live_converter_rate_o        <= CFG_W'(CONV_RATE_RST);
      live_converter_acquisition_o <= CFG_W'(CONV_ACQ_RST);
      live_serial_port_config_o    <= CFG_W'(SPI_CFG_RST);
      halt_o                       <= 1'b0;
      reduced_power_state_o        <= 1'b0;
    end else begin
      state                        <= next_state;
      addr                         <= next_addr;
      rd_data_o                    <= next_rd_data;
      rd_ready_o                   <= next_rd_ready;
      cmd_valid_o                  <= next_cmd_valid;
      capture_shadow_o             <= next_capture;
      live_converter_config_o      <= next_cfg;
      live_converter_rate_o        <= next_rate;
      live_converter_acquisition_o <= next_acq;
      live_serial_port_config_o    <= next_spi;
      halt_o                       <= next_halt;
      reduced_power_state_o        <= next_low_power;
    end
  end

  // Checker helpers: the last two samples taken during a measurement.
  logic [DATA_W-1:0] seen0;
  logic [DATA_W-1:0] seen1;
  logic [DATA_W:0]   seen_sum;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seen0 <= ZERO_WORD;
      seen1 <= ZERO_WORD;
    end else if (temp_sample_ack_i && temp_sample_req_o) begin
      seen0 <= seen1;
      seen1 <= temp_sample_i;
    end
  end

  assign seen_sum = {1'b0, seen0} + {1'b0, seen1};

  // Checker helper: the address offered with a start names a command.
  logic start_is_cmd;

  assign start_is_cmd = cmd_addr_i inside {ADDR_APPLY_SHADOW,
    ADDR_CAPTURE_SHADOW, ADDR_FW_VERSION, ADDR_RAW_TEMP, ADDR_HALT_ENTRY,
    ADDR_LP_ENTRY, ADDR_LP_EXIT};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_accept(logic [ADDR_W-1:0] a);
    cmd_start_i && (state != CMD_MEASURE) && (cmd_addr_i == a);
  endsequence

  sequence s_complete(logic [ADDR_W-1:0] a);
    (state == CMD_READY) && cmd_done_i && (addr == a);
  endsequence

  a_filler_answer: assert property (
    s_accept(ADDR_APPLY_SHADOW) |=> rd_ready_o &&
      (rd_data_o == {ZERO_BYTE, FILLER_BYTE}))
    else $error("filler answer missing");

  a_apply_copies_shadow: assert property (
    s_complete(ADDR_APPLY_SHADOW) ##0 !cmd_start_i |=>
      (live_converter_config_o == $past(converter_config_shadow_i)) &&
      (live_serial_port_config_o == $past(serial_port_config_shadow_i)) &&
      (state == CMD_IDLE))
    else $error("apply read did not copy shadows");

  a_capture_pulse_cause: assert property (
    capture_shadow_o |-> $past(fire) && ($past(addr) == ADDR_CAPTURE_SHADOW)
      ##1 (capture_shadow_o ==
        ($past(fire) && ($past(addr) == ADDR_CAPTURE_SHADOW))))
    else $error("capture pulse without capture read");

  a_version_word: assert property (
    s_accept(ADDR_FW_VERSION) |=> rd_ready_o && (rd_data_o == FW_VERSION))
    else $error("version word wrong");

  a_temp_measure_start: assert property (
    s_accept(ADDR_RAW_TEMP) |=> temp_sample_req_o && !rd_ready_o &&
      (state == CMD_MEASURE))
    else $error("temperature measurement not started");

  a_temp_average: assert property (
    (state == CMD_MEASURE) && avg_done |=> rd_ready_o &&
      (rd_data_o == $past(seen_sum[DATA_W:1])))
    else $error("temperature average wrong");

  a_halt_entry: assert property (
    s_complete(ADDR_HALT_ENTRY) |=> halt_o)
    else $error("halt not entered");

  a_lowpower_entry: assert property (
    s_complete(ADDR_LP_ENTRY) ##1 !(fire && (addr == ADDR_LP_EXIT)) |->
      reduced_power_state_o [*2])
    else $error("low power not entered");

  a_lowpower_exit: assert property (
    s_complete(ADDR_LP_EXIT) |=> !reduced_power_state_o)
    else $error("low power not left");

  a_live_regs_stable: assert property (
    !(fire && (addr == ADDR_APPLY_SHADOW)) |=>
      $stable(live_converter_config_o) && $stable(live_converter_rate_o) &&
      $stable(live_converter_acquisition_o) &&
      $stable(live_serial_port_config_o))
    else $error("live register changed without apply read");

  a_lowpower_stable: assert property (
    !(fire && ((addr == ADDR_LP_ENTRY) || (addr == ADDR_LP_EXIT))) |=>
      $stable(reduced_power_state_o))
    else $error("low power state changed without command");

  a_unmapped_answer: assert property (
    cmd_start_i && (state != CMD_MEASURE) && !start_is_cmd |=>
      rd_ready_o && !cmd_valid_o && (rd_data_o == ZERO_WORD))
    else $error("unmapped read answered as a command");

  a_command_flagged: assert property (
    cmd_start_i && (state != CMD_MEASURE) && start_is_cmd |=> cmd_valid_o)
    else $error("command read not flagged valid");

  a_wake_ends_halt: assert property (
    wake_sync && !(fire && (addr == ADDR_HALT_ENTRY)) |=> !halt_o)
    else $error("wake did not end the stop state");

  a_measure_holds_addr: assert property (
    (state == CMD_MEASURE) |=> $stable(addr))
    else $error("read accepted during a measurement");

endmodule // virtual_register_command_decoder

`default_nettype wire

// ### dv/host_read_model.sv
// Host model that frames single reads towards the command decoder.
`timescale 1ns/1ps
`default_nettype none

module host_read_model
  import vreg_cmd_pkg::*;
(
  // Clock.
  input  wire logic              clk_i,
  // Requests from the bench.
  input  wire logic              go_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [1:0]        gap_i,
  output logic                   busy_o,
  output logic                   late_o,
  output logic [DATA_W-1:0]      data_o,
  // Framer side of the decoder.
  input  wire logic              rd_ready_i,
  input  wire logic [DATA_W-1:0] rd_data_i,
  output logic                   cmd_start_o,
  output logic [ADDR_W-1:0]      cmd_addr_o,
  output logic                   cmd_done_o
);
  int n;

  initial begin
    {busy_o, late_o, cmd_start_o, cmd_done_o} = '0;
    data_o = '0;
    cmd_addr_o = '0;
  end

  always @(negedge clk_i) begin
    if (go_i) begin
      busy_o <= 1'b1;
      cmd_start_o <= 1'b1;
      cmd_addr_o <= addr_i;
      n = 0;
      do begin
        @(negedge clk_i);
        cmd_start_o <= 1'b0;
        // The address is only valid with the start; scramble it after.
        cmd_addr_o <= ~addr_i;
        n++;
      end while (!rd_ready_i && n < 40);
      late_o <= (n >= 40);
      data_o <= rd_data_i;
      repeat (gap_i) @(negedge clk_i);
      cmd_done_o <= 1'b1;
      @(negedge clk_i);
      cmd_done_o <= 1'b0;
      busy_o <= 1'b0;
    end
  end
endmodule // host_read_model

`default_nettype wire

// ### dv/virtual_register_command_decoder_tb_top.sv
// Self-checking bench for the virtual register command decoder.
`timescale 1ns/1ps
`default_nettype none

module virtual_register_command_decoder_tb_top
  import vreg_cmd_pkg::*;
;
  // Version value is arbitrary.
  localparam logic [15:0] FW   = 16'h5a3c;
  localparam logic [15:0] FILL = {8'h00, FILLER_BYTE};
  localparam logic [11:0] TBL [6] = '{ADDR_APPLY_SHADOW, ADDR_CAPTURE_SHADOW,
    ADDR_FW_VERSION, ADDR_RAW_TEMP, ADDR_LP_ENTRY, ADDR_LP_EXIT};

  logic        clk_i  = 1'b0;
  logic        rstn_i = 1'b0;
  logic        go     = 1'b0;
  logic        wake   = 1'b0;
  logic        ack    = 1'b0;
  logic        kk     = 1'b0;
  logic        eh     = 1'b0;
  logic        elp    = 1'b0;
  logic [11:0] addr   = '0;
  logic [1:0]  gap    = '0;
  logic [2:0]  wc     = '0;
  logic [15:0] smp_v  = '0;
  logic [31:0] seed   = 32'd98;
  logic [31:0] t, ts;
  logic [63:0] elive  = '0;
  logic        start, done, rdy, vld, cap, busy, late, halt, lp, req;
  logic [11:0] caddr;
  logic [15:0] rdat, hdat;
  logic [15:0] sh [4];
  logic [15:0] lv [4];
  logic [15:0] smp [2];
  int          miscompares = 0;
  int          compares = 0;
  int          ncap = 0;
  int          ecap = 0;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  initial forever #10 clk_i = ~clk_i;

  // Die sampler: acks after a random wait, line scrambled while idle.
  always @(negedge clk_i) begin
    ack <= 1'b0;
    smp_v <= ~smp_v;
    if (req && !ack) begin
      if (wc == 3'd0) begin
        ts = xs();
        ack <= 1'b1;
        smp_v <= ts[15:0];
        smp[kk] <= ts[15:0];
        kk <= ~kk;
        wc <= {1'b0, ts[17:16]} + 3'd1;
      end else begin
        wc <= wc - 3'd1;
      end
    end
  end

  // Shadow store loads from the live registers on a capture pulse.
  always @(negedge clk_i) begin
    if (cap) begin
      sh <= lv;
      ncap <= ncap + 1;
    end
  end

  virtual_register_command_decoder #(.FW_VERSION(FW)) uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .cmd_start_i(start),
    .cmd_addr_i(caddr), .cmd_done_i(done), .rd_data_o(rdat),
    .rd_ready_o(rdy), .cmd_valid_o(vld),
    .converter_config_shadow_i(sh[0]), .converter_rate_shadow_i(sh[1]),
    .converter_acquisition_shadow_i(sh[2]),
    .serial_port_config_shadow_i(sh[3]), .capture_shadow_o(cap),
    .live_converter_config_o(lv[0]), .live_converter_rate_o(lv[1]),
    .live_converter_acquisition_o(lv[2]),
    .live_serial_port_config_o(lv[3]), .wake_i(wake), .halt_o(halt),
    .reduced_power_state_o(lp), .temp_sample_req_o(req),
    .temp_sample_ack_i(ack), .temp_sample_i(smp_v));

  host_read_model host (
    .clk_i(clk_i), .go_i(go), .addr_i(addr), .gap_i(gap), .busy_o(busy),
    .late_o(late), .data_o(hdat), .rd_ready_i(rdy), .rd_data_i(rdat),
    .cmd_start_o(start), .cmd_addr_o(caddr), .cmd_done_o(done));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string msg);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    logic [16:0] avg;
    logic        ev;
    @(negedge clk_i);
    t = xs();
    addr = a;
    gap = t[1:0];
    go <= 1'b1;
    @(negedge clk_i);
    go <= 1'b0;
    n = 0;
    // The host raises busy on the edge that takes go; look one edge later.
    do begin
      @(negedge clk_i);
      n++;
    end while (busy && n < 100);
    if (n >= 100 || late) begin
      miscompares++;
      final_report();
    end
    @(negedge clk_i);
    ev = 1'b1;
    avg = ({1'b0, smp[0]} + {1'b0, smp[1]}) >> 1;
    case (a)
      ADDR_FW_VERSION: chk(hdat, FW, "version");
      ADDR_RAW_TEMP: begin
        chk(hdat, avg[15:0], "temperature");
        chk(hdat[7:0], avg[7:0], "first byte");
      end
      ADDR_APPLY_SHADOW: begin
        chk(hdat, FILL, "apply filler");
        elive = {sh[0], sh[1], sh[2], sh[3]};
      end
      ADDR_CAPTURE_SHADOW: begin
        chk(hdat, FILL, "capture filler");
        chk({sh[0], sh[1], sh[2], sh[3]}, elive, "shadows");
        ecap++;
      end
      ADDR_HALT_ENTRY: begin
        chk(hdat, FILL, "halt filler");
        eh = 1'b1;
      end
      ADDR_LP_ENTRY: begin
        chk(hdat, FILL, "entry filler");
        elp = 1'b1;
      end
      ADDR_LP_EXIT: begin
        chk(hdat, FILL, "exit filler");
        elp = 1'b0;
      end
      default: begin
        ev = 1'b0;
        chk(hdat, ZERO_WORD, "unmapped");
      end
    endcase
    chk({lv[0], lv[1], lv[2], lv[3]}, elive, "live regs");
    chk(ncap, ecap, "capture count");
    chk({halt, lp}, {eh, elp}, "power state");
    chk(rdy, 1'b0, "ready held");
    chk(vld, ev, "command valid");
    chk(req, 1'b0, "sampler idle");
  endtask

  initial begin
    for (int i = 0; i < 4; i++) sh[i] = '0;
    repeat (12) @(negedge clk_i);
    chk({lv[0], lv[1], lv[2], lv[3]}, elive, "reset live");
    chk({rdat, rdy, vld, cap, halt, lp, req}, 22'h000000,
        "reset outputs");
    rstn_i = 1'b1;
    rd(ADDR_FW_VERSION);
    for (int j = 0; j < 4; j++) begin
      t = xs();
      sh[j] = t[15:0];
    end
    rd(ADDR_APPLY_SHADOW);
    rd(ADDR_CAPTURE_SHADOW);
    rd(12'h901);
    repeat (3) rd(ADDR_RAW_TEMP);
    rd(ADDR_LP_ENTRY);
    rd(ADDR_LP_EXIT);
    rd(ADDR_HALT_ENTRY);
    wake = 1'b1;
    repeat (5) @(negedge clk_i);
    wake = 1'b0;
    eh = 1'b0;
    chk(halt, 1'b0, "wake");
    for (int i = 0; i < 40; i++) begin
      for (int j = 0; j < 4; j++) begin
        t = xs();
        sh[j] = t[15:0];
      end
      t = xs();
      rd(t[2:0] < 3'd6 ? TBL[t[2:0]] : {1'b0, t[13:3]});
    end
    rd(ADDR_LP_ENTRY);
    @(negedge clk_i);
    rstn_i = 1'b0;
    {eh, elp} = 2'b00;
    elive = '0;
    repeat (12) @(negedge clk_i);
    chk({lv[0], lv[1], lv[2], lv[3]}, elive, "reset live again");
    chk({halt, lp}, 2'b00, "reset power");
    rstn_i = 1'b1;
    rd(ADDR_APPLY_SHADOW);
    final_report();
  end
endmodule // virtual_register_command_decoder_tb_top

`default_nettype wire
